/* File: shared/ssp_defs.svh */
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH
// Register offsets on the plain register port
`define SSP_OFS_STAT 2'h0
`define SSP_OFS_CTL 2'h1
`define SSP_OFS_BUF 2'h2
`define SSP_OFS_FLAG 2'h3
// Status register fields
`define SSP_STAT_SMP 7
`define SSP_STAT_CKE 6
`define SSP_STAT_BF 0
// Control register fields
`define SSP_CTL_WRITE_COLLISION_FLAG 7
`define SSP_CTL_OV 6
`define SSP_CTL_EN 5
`define SSP_CTL_CKP 4
// Flag register field
`define SSP_FLAG_IF 0
// Reset values
`define SSP_STAT_RST 2'h0
`define SSP_CTL_RST 8'h00
// Mode select codes
`define SSP_MODE_M4 4'h0
`define SSP_MODE_M16 4'h1
`define SSP_MODE_M64 4'h2
`define SSP_MODE_MTMR 4'h3
`define SSP_MODE_SSS 4'h4
`define SSP_MODE_SNOSS 4'h5
// Master clock half periods in mclk cycles (full period 4, 16, 64)
`define SSP_HALF_4 5'h02
`define SSP_HALF_16 5'h08
`define SSP_HALF_64 5'h20
// Master edge steps: 16 clock edges plus one closing step
`define SSP_LAST_EDGE 5'h10
`endif

/* File: shared/ssp_pkg.sv */
package ssp_pkg;
	typedef enum logic {SSP_IDLE, SSP_RUN} ssp_mst_e;
endpackage

/* File: design/ssp_spi.sv */
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "ssp_defs.svh"

// Overview of operation
// - Each transfer shifts eight bits out and eight bits in together, on the clock.
// - All four clock idle level and sampling edge combinations are supported.
// - Three lines carry ordinary traffic: data out, data in, serial clock.
// - As slave, an optional select input from the master qualifies transfers.
// - Every bit of the control register is readable and writable by software.
// - Low six status bits are read-only; software writes there do nothing.
// - Top two status bits, sampling and clock edge, are read-write.
// - The shift register is never visible directly, only through the buffer.
// - One buffer register carries both outgoing and incoming bytes.
// - A completed byte moves to the buffer and sets the port interrupt flag.
// - Transmit has no holding stage; the buffer is single on that side.
// - A buffer write loads buffer and shift register in the same cycle.
// - Bytes go out and come in most significant bit first.
// - Buffer write during a transfer is dropped and sets collision flag.
// - Buffer-full sets when a byte lands, clears when software reads buffer.
// - Slave byte arriving onto an unread buffer sets overflow and is lost.
module ssp_spi (
	// Core clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Register port
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Timer tick for the timer-paced master rate
	input wire logic timer_tick,
	// Serial link
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	input wire logic ss_n,
	// Event flag
	output logic serial_port_interrupt_flag
);
	// Register state
	logic [1:0] cfg_r, cfg_nxt;
	logic [7:0] ctl_r, ctl_nxt;
	logic [7:0] buf_r, buf_nxt;
	logic [7:0] tx_r, tx_nxt;
	logic bf_r, bf_nxt;
	logic flag_r, flag_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	// Master engine state
	ssp_pkg::ssp_mst_e st_r, st_nxt;
	logic [4:0] div_r, div_nxt;
	logic [4:0] edge_r, edge_nxt;
	logic sck_r, sck_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic [7:0] mrx_r, mrx_nxt;
	logic [1:0] sq_r, sq_nxt;
	logic [1:0] lq_r, lq_nxt;
	// Synchronisers
	logic [1:0] sdi_s_r;
	logic [1:0] ssn_s_r;
	logic [1:0] lbusy_s_r;
	logic [2:0] done_s_r;
	// Link domain state
	logic [2:0] lcnt_r, lcnt_nxt;
	logic [7:0] lrx_r, lrx_nxt;
	logic [7:0] lword_r, lword_nxt;
	logic ldone_r, ldone_nxt;
	logic lbusy_r, lbusy_nxt;
	logic [2:0] lout_r;
	// Decoded controls
	logic en, ckp, cke, smp, is_mst, is_slv, ss_ctl;
	logic lclk, lrst_n, busy, tick, s_done;
	logic [4:0] half;
	logic samp_pt, shift_pt;

	// Control decode
	assign en = ctl_r[`SSP_CTL_EN];
	assign ckp = ctl_r[`SSP_CTL_CKP];
	assign cke = cfg_r[0];
	assign smp = cfg_r[1];
	assign is_mst = (ctl_r[3:2] == 2'h0);
	assign ss_ctl = (ctl_r[3:0] == `SSP_MODE_SSS);
	assign is_slv = ss_ctl | (ctl_r[3:0] == `SSP_MODE_SNOSS);

	// Link clock: rising edge is the sampling edge in every mode
	assign lclk = sck_in ^ ckp ^ ~cke;
	// Deselect or disable holds the slave shifter idle
	assign lrst_n = reset_n & en & is_slv & ~(ss_ctl & ss_n);

	// Slave shifter, sample edge
	always_comb begin
		lrx_nxt = {lrx_r[6:0], sdi};
		lcnt_nxt = lcnt_r + 3'h1;
		lbusy_nxt = (lcnt_nxt != 3'h0);
	end

	always_ff @(posedge lclk or negedge lrst_n) begin
		if (!lrst_n) begin
			lcnt_r <= 3'h0;
			lrx_r <= 8'h00;
			lbusy_r <= 1'b0;
		end else begin
			lcnt_r <= lcnt_nxt;
			lrx_r <= lrx_nxt;
			lbusy_r <= lbusy_nxt;
		end
	end

	// Completed word and its toggle survive deselect, so no false event on release
	always_comb begin
		lword_nxt = lword_r;
		ldone_nxt = ldone_r;
		if (lcnt_r == 3'h7) begin
			lword_nxt = lrx_nxt;
			ldone_nxt = ~ldone_r;
		end
	end

	always_ff @(posedge lclk or negedge reset_n) begin
		if (!reset_n) begin
			lword_r <= 8'h00;
			ldone_r <= 1'b0;
		end else begin
			lword_r <= lword_nxt;
			ldone_r <= ldone_nxt;
		end
	end

	// Output bit index moves on the edge opposite to sampling
	always_ff @(negedge lclk or negedge lrst_n) begin
		if (!lrst_n) begin
			lout_r <= 3'h0;
		end else begin
			lout_r <= lcnt_r;
		end
	end

	// Crossings into the core clock
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sdi_s_r <= 2'h0;
			ssn_s_r <= 2'h3;
			lbusy_s_r <= 2'h0;
			done_s_r <= 3'h0;
		end else begin
			sdi_s_r <= {sdi_s_r[0], sdi};
			ssn_s_r <= {ssn_s_r[0], ss_n};
			lbusy_s_r <= {lbusy_s_r[0], lbusy_r};
			done_s_r <= {done_s_r[1:0], ldone_r};
		end
	end

	assign s_done = done_s_r[2] ^ done_s_r[1];
	assign busy = is_mst ? (st_r == ssp_pkg::SSP_RUN) : lbusy_s_r[1];

	// Master pacing and edge classification
	always_comb begin
		unique case (ctl_r[1:0])
			2'h0: half = `SSP_HALF_4;
			2'h1: half = `SSP_HALF_16;
			2'h2: half = `SSP_HALF_64;
			default: half = `SSP_HALF_4;
		endcase
	end

	assign tick = (ctl_r[3:0] == `SSP_MODE_MTMR) ? timer_tick : (div_r == half - 5'h01);
	// Even steps are idle-to-active edges; smp moves sampling half a period later
	assign samp_pt = smp ? ((edge_r != 5'h00) && (cke ? edge_r[0] : ~edge_r[0]))
		: ((edge_r < `SSP_LAST_EDGE) && (cke ? ~edge_r[0] : edge_r[0]));
	assign shift_pt = (cke ? edge_r[0] : ~edge_r[0]) && (edge_r != 5'h00)
		&& (edge_r < 5'h0f);

	// Register access, master engine and event capture
	always_comb begin
		cfg_nxt = cfg_r;
		ctl_nxt = ctl_r;
		buf_nxt = buf_r;
		tx_nxt = tx_r;
		bf_nxt = bf_r;
		flag_nxt = flag_r;
		rdata_nxt = 8'h00;
		st_nxt = st_r;
		div_nxt = div_r;
		edge_nxt = edge_r;
		sck_nxt = sck_r;
		idx_nxt = idx_r;
		mrx_nxt = mrx_r;
		sq_nxt = {sq_r[0], 1'b0};
		lq_nxt = {lq_r[0], 1'b0};
		// Reads: answer stands one cycle after the strobe
		if (reg_rd) begin
			unique case (reg_addr)
				`SSP_OFS_STAT: rdata_nxt = {cfg_r, 5'h00, bf_r};
				`SSP_OFS_CTL: rdata_nxt = ctl_r;
				`SSP_OFS_BUF: begin
					rdata_nxt = buf_r;
					bf_nxt = 1'b0;
				end
				`SSP_OFS_FLAG: rdata_nxt = {7'h00, flag_r};
			endcase
		end
		// Writes
		if (reg_wr) begin
			unique case (reg_addr)
				`SSP_OFS_STAT: cfg_nxt = reg_wdata[7:6];
				`SSP_OFS_CTL: ctl_nxt = reg_wdata;
				`SSP_OFS_BUF: begin
					if (busy) begin
						ctl_nxt[`SSP_CTL_WRITE_COLLISION_FLAG] = 1'b1;
					end else begin
						buf_nxt = reg_wdata;
						tx_nxt = reg_wdata;
						if (en && is_mst) begin
							st_nxt = ssp_pkg::SSP_RUN;
							edge_nxt = 5'h00;
							idx_nxt = 3'h0;
							div_nxt = 5'h00;
						end
					end
				end
				`SSP_OFS_FLAG: begin
					if (reg_wdata[`SSP_FLAG_IF]) begin
						flag_nxt = 1'b0;
					end
				end
			endcase
		end
		// Master engine: 16 clock edges then a closing step
		if (!en || !is_mst) begin
			st_nxt = ssp_pkg::SSP_IDLE;
			sck_nxt = ckp;
		end else if (st_r == ssp_pkg::SSP_IDLE) begin
			sck_nxt = ckp; // Clock rests at its idle level
		end else if (tick && (edge_r <= `SSP_LAST_EDGE)) begin
			div_nxt = 5'h00;
			edge_nxt = edge_r + 5'h01;
			if (edge_r < `SSP_LAST_EDGE) begin
				sck_nxt = ~sck_r;
			end
			if (samp_pt) begin
				sq_nxt[0] = 1'b1;
			end
			if (shift_pt) begin
				idx_nxt = idx_r + 3'h1;
			end
			if (edge_r == `SSP_LAST_EDGE) begin
				lq_nxt[0] = 1'b1;
			end
		end else begin
			div_nxt = div_r + 5'h01;
		end
		// The input synchroniser lags two cycles, so capture trails each sampling edge by two
		if (en && is_mst && (st_r == ssp_pkg::SSP_RUN)) begin
			if (sq_r[1]) begin
				mrx_nxt = {mrx_r[6:0], sdi_s_r[1]};
			end
			if (lq_r[1]) begin
				st_nxt = ssp_pkg::SSP_IDLE;
				buf_nxt = mrx_nxt;
				bf_nxt = 1'b1;
				flag_nxt = 1'b1;
			end
		end
		// Slave byte: placed last so a same-cycle clear loses to the set
		if (s_done && en && is_slv) begin
			flag_nxt = 1'b1;
			if (bf_nxt) begin
				ctl_nxt[`SSP_CTL_OV] = 1'b1;
			end else begin
				buf_nxt = lword_r;
				bf_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_r <= `SSP_STAT_RST;
			ctl_r <= `SSP_CTL_RST;
			buf_r <= 8'h00;
			tx_r <= 8'h00;
			bf_r <= 1'b0;
			flag_r <= 1'b0;
			rdata_r <= 8'h00;
			st_r <= ssp_pkg::SSP_IDLE;
			div_r <= 5'h00;
			edge_r <= 5'h00;
			sck_r <= 1'b0;
			idx_r <= 3'h0;
			mrx_r <= 8'h00;
			sq_r <= 2'h0;
			lq_r <= 2'h0;
		end else begin
			cfg_r <= cfg_nxt;
			ctl_r <= ctl_nxt;
			buf_r <= buf_nxt;
			tx_r <= tx_nxt;
			bf_r <= bf_nxt;
			flag_r <= flag_nxt;
			rdata_r <= rdata_nxt;
			st_r <= st_nxt;
			div_r <= div_nxt;
			edge_r <= edge_nxt;
			sck_r <= sck_nxt;
			idx_r <= idx_nxt;
			mrx_r <= mrx_nxt;
			sq_r <= sq_nxt;
			lq_r <= lq_nxt;
		end
	end

	// Pins; tx_r is stable during a transfer since colliding writes are dropped
	assign sck_out = sck_r;
	assign sck_oe = en & is_mst;
	assign sdo = is_mst ? tx_r[~idx_r] : tx_r[~lout_r];
	assign sdo_oe = en & (is_mst | (is_slv & ~(ss_ctl & ssn_s_r[1])));
	assign reg_rdata = rdata_r;
	assign serial_port_interrupt_flag = flag_r;
endmodule

/* File: sim/ssp_spi_checker.sv */
`timescale 1ns/100ps
`include "ssp_defs.svh"
module ssp_spi_checker (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Register port
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Serial link and event flag
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic sdo_oe,
	input wire logic serial_port_interrupt_flag
);
	logic [7:0] ctl_r;
	logic [1:0] st_r;
	logic [4:0] tog_r;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Shadow software-owned bits; count clock edges between completed bytes
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctl_r <= 8'h00;
			st_r <= 2'h0;
			tog_r <= 5'h00;
		end else begin
			if (reg_wr && reg_addr == `SSP_OFS_CTL) ctl_r <= reg_wdata;
			if (reg_wr && reg_addr == `SSP_OFS_STAT) st_r <= reg_wdata[7:6];
			if ($rose(serial_port_interrupt_flag) || !sck_oe) tog_r <= 5'h00;
			else if ($changed(sck_out)) tog_r <= tog_r + 5'h01;
		end
	end
	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	AST_STAT_RO: assert property (reg_rd && reg_addr == `SSP_OFS_STAT |=> reg_rdata[5:1] == 5'h00)
		else $error("status low bits not read-only");
	AST_STAT_RW: assert property (reg_rd && reg_addr == `SSP_OFS_STAT |=> reg_rdata[7:6] == st_r)
		else $error("status top bits lost");
	AST_CTL_RW: assert property (reg_rd && reg_addr == `SSP_OFS_CTL |=> reg_rdata[5:0] == ctl_r[5:0])
		else $error("control readback wrong");
	AST_FLAG_HOLD: assert property (serial_port_interrupt_flag
		&& !(reg_wr && reg_addr == `SSP_OFS_FLAG && reg_wdata[0]) |=> serial_port_interrupt_flag)
		else $error("event flag dropped");
	AST_BYTE_EDGES: assert property ($rose(serial_port_interrupt_flag) && sck_oe |-> tog_r == 5'h10)
		else $error("master byte without sixteen clock edges");
	AST_SCK_OWNER: assert property (sck_oe |-> ctl_r[`SSP_CTL_EN] && ctl_r[3:0] <= `SSP_MODE_MTMR)
		else $error("clock driven outside master mode");
	AST_SDO_WITH_SCK: assert property (sck_oe |-> sdo_oe)
		else $error("data out idle while clock driven");
	// Main traffic seen
	cover property ($rose(serial_port_interrupt_flag) && sck_oe);
	cover property ($rose(serial_port_interrupt_flag) && !sck_oe);
	cover property (reg_wr && reg_addr == `SSP_OFS_BUF && sck_oe);
endmodule

bind ssp_spi ssp_spi_checker ssp_spi_checker_inst (.mclk, .reset_n, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .sck_out, .sck_oe, .sdo_oe, .serial_port_interrupt_flag);

/* File: sim/ssp_peer.sv */
`timescale 1ns/100ps
module ssp_peer (
	// Serial clock on the wire, from whichever end is master
	input wire logic sck,
	// Data lines
	input wire logic din,
	output logic dout,
	// Byte to send, byte received
	input wire logic load,
	input wire logic [7:0] tx,
	output logic [7:0] rx
);
	logic [7:0] sh_r;
	// Shift on the trailing edge; past the byte the line carries the complement of the byte
	assign dout = sh_r[7];
	always @(posedge load or negedge sck) begin
		if (load) sh_r <= tx;
		else sh_r <= {sh_r[6:0], ~sh_r[7]};
	end
	// Sample on the leading edge, idle low
	always @(posedge sck) begin
		rx <= {rx[6:0], din};
	end
endmodule

/* File: sim/ssp_spi_test.sv */
`timescale 1ns/100ps
`include "ssp_defs.svh"
module ssp_spi_test;
	logic mclk, lclk, reset_n, reg_wr, reg_rd, go, load, sck_oe, sck_out, sdo, flag, pdo;
	logic ssn, soe;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, ptx, prx;
	int failures, checked;
	wire logic sck_m = go & lclk; // Far master clock stands still between frames
	wire logic wsck = sck_oe ? sck_out : sck_m;
	ssp_spi ssp_spi_inst (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.timer_tick(1'b0), .sck_in(sck_m), .sck_out(sck_out), .sck_oe(sck_oe), .sdi(pdo),
		.sdo(sdo), .sdo_oe(soe), .ss_n(ssn), .serial_port_interrupt_flag(flag));
	ssp_peer ssp_peer_inst (.sck(wsck), .din(sdo), .dout(pdo), .load(load), .tx(ptx), .rx(prx));
	// Core and link clocks, unrelated phase
	initial begin
		mclk = 0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		lclk = 0;
		#7;
		forever #24 lclk = ~lclk;
	end
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// Bounded wait for a completed byte, then clear the flag
	task wait_flag;
		for (int n = 0; n < 400 && flag !== 1'b1; n++) @(posedge mclk);
		chk({7'h00, flag}, 8'h01);
		wr(`SSP_OFS_FLAG, 8'h01);
	endtask
	task frame(input logic [7:0] t);
		ptx = t;
		load = 1;
		#1 load = 0;
		@(negedge lclk) go <= 1'b1;
		repeat (8) @(posedge lclk);
		@(negedge lclk) go <= 1'b0;
	endtask
	task test_done;
		if (failures == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		test_done;
	end
	initial begin
		{reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, go, load, ptx} = '0;
		ssn = 1'b1;
		failures = 0;
		checked = 0;
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		rd(`SSP_OFS_STAT, 8'h00);
		rd(`SSP_OFS_CTL, 8'h00);
		rd(`SSP_OFS_FLAG, 8'h00);
		wr(`SSP_OFS_CTL, 8'hff);
		rd(`SSP_OFS_CTL, 8'hff);
		wr(`SSP_OFS_CTL, 8'h00);
		wr(`SSP_OFS_STAT, 8'hff);
		rd(`SSP_OFS_STAT, 8'hc0);
		wr(`SSP_OFS_STAT, 8'h40);
		// Master byte with a colliding second write
		ptx = 8'ha5;
		load = 1;
		#1 load = 0;
		wr(`SSP_OFS_CTL, 8'h20);
		wr(`SSP_OFS_BUF, 8'h3c);
		wr(`SSP_OFS_BUF, 8'h55);
		wait_flag;
		chk(prx, 8'h3c);
		rd(`SSP_OFS_FLAG, 8'h00);
		rd(`SSP_OFS_STAT, 8'h41);
		rd(`SSP_OFS_BUF, 8'ha5);
		rd(`SSP_OFS_STAT, 8'h40);
		rd(`SSP_OFS_CTL, 8'ha0);
		// Slave bytes, the third onto an unread buffer
		wr(`SSP_OFS_CTL, 8'h00);
		wr(`SSP_OFS_CTL, 8'h25);
		wr(`SSP_OFS_BUF, 8'hc3);
		frame(8'h96);
		wait_flag;
		chk(prx, 8'hc3);
		rd(`SSP_OFS_BUF, 8'h96);
		frame(8'h5a);
		wait_flag;
		frame(8'h0f);
		wait_flag;
		rd(`SSP_OFS_BUF, 8'h5a);
		rd(`SSP_OFS_CTL, 8'h65);
		// Select line gates the slave data output
		wr(`SSP_OFS_CTL, 8'h24);
		repeat (3) @(posedge mclk);
		chk({7'h00, soe}, 8'h00);
		ssn <= 1'b0;
		repeat (3) @(posedge mclk);
		chk({7'h00, soe}, 8'h01);
		test_done;
	end
endmodule
